/* rtl/fws_bus_cycle.sv */
// Pin engine: runs one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module fws_bus_cycle
	import fws_pkg::*;
#(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
)(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              clk_en,
	// Sequencer side
	fws_cyc_if.eng                 cyc,
	// Flash pins
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [DATA_W-1:0]      flash_dq_out,
	output logic                   flash_dq_oe_n,
	input  wire logic [DATA_W-1:0] flash_dq_in
);
	typedef enum logic [2:0] {
		ENG_IDLE    = 3'b001,
		ENG_STROBE  = 3'b010,
		ENG_RECOVER = 3'b100
	} fws_eng_e;

	fws_eng_e          state;
	logic [7:0]        cnt;
	logic              wr_q;
	logic [DATA_W-1:0] dq_s1;
	logic [DATA_W-1:0] dq_s2;

	// ********************************************************************
	// Data pin synchroniser
	// ********************************************************************
	// Read data is only sampled from the second stage
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			dq_s1 <= '0;
			dq_s2 <= '0;
		end
		else if (clk_en)
		begin
			dq_s1 <= flash_dq_in;
			dq_s2 <= dq_s1;
		end

	// ********************************************************************
	// Cycle sequencing
	// ********************************************************************
	// Strobe rises before chip select so data and address hold past the latch edge
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			state         <= ENG_IDLE;
			cnt           <= 8'h00;
			wr_q          <= 1'b0;
			flash_ce_n    <= 1'b1;
			flash_oe_n    <= 1'b1;
			flash_we_n    <= 1'b1;
			flash_addr    <= '0;
			flash_dq_out  <= '0;
			flash_dq_oe_n <= 1'b1;
			cyc.done      <= 1'b0;
			cyc.rdata     <= '0;
		end
		else if (clk_en)
		begin
			cyc.done <= 1'b0;
			case (state)
				ENG_IDLE:
					if (cyc.req && !cyc.done)
					begin
						wr_q          <= cyc.wr;
						flash_addr    <= cyc.addr;
						flash_dq_out  <= cyc.wdata;
						flash_ce_n    <= 1'b0;
						flash_we_n    <= !cyc.wr;
						flash_oe_n    <= cyc.wr;
						flash_dq_oe_n <= !cyc.wr;
						// Reads stretch by the synchroniser depth before sampling
						cnt           <= cyc.wr ? 8'(STROBE_CYC - 1) : 8'(STROBE_CYC + SYNC_CYC - 1);
						state         <= ENG_STROBE;
					end
				ENG_STROBE:
					if (cnt == 8'h00)
					begin
						flash_we_n <= 1'b1; // Rising edge latches the command [R02]
						flash_oe_n <= 1'b1; // Rising edge ends the read, toggle advances [R23]
						if (!wr_q)
							cyc.rdata <= dq_s2;
						cnt   <= 8'(RECOVER_CYC - 1);
						state <= ENG_RECOVER;
					end
					else
						cnt <= cnt - 8'h01;
				ENG_RECOVER:
					if (cnt == 8'h00)
					begin
						flash_ce_n    <= 1'b1;
						flash_dq_oe_n <= 1'b1;
						cyc.done      <= 1'b1;
						state         <= ENG_IDLE;
					end
					else
						cnt <= cnt - 8'h01;
				default:
					state <= ENG_IDLE;
			endcase
		end

	// Counts must fit the 8-bit cycle counter
	if (STROBE_CYC + SYNC_CYC > 255 || RECOVER_CYC > 255)
		$error("fws_bus_cycle: strobe timing too long for counter");
endmodule

/* rtl/fws_cyc_if.sv */
// Bus cycle request and answer between the poll sequencer and the pin engine
`timescale 1ns/1ps
interface fws_cyc_if #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
);
	logic              req;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              done;
	logic [DATA_W-1:0] rdata;

	modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* rtl/fws_host.sv */
// Flash host: issues program, erase and suspend sequences and polls the status word
`timescale 1ns/1ps
module fws_host
	import fws_pkg::*;
#(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
)(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  clk_en,
	// User command port
	input  wire logic                  cmd_valid,
	input  wire fws_pkg::fws_op_e      cmd_op,
	input  wire logic [ADDR_W-1:0]     cmd_addr,
	input  wire logic [DATA_W-1:0]     cmd_data,
	output logic                       cmd_ready,
	// User answer port
	output logic                       resp_valid,
	output logic                       resp_ok,
	output logic [DATA_W-1:0]          resp_data,
	output logic [fws_pkg::STATUS_W-1:0] status_word,
	output logic                       erase_started,
	output logic                       device_busy,
	// Flash pins
	output logic                       flash_ce_n,
	output logic                       flash_oe_n,
	output logic                       flash_we_n,
	output logic [ADDR_W-1:0]          flash_addr,
	output logic [DATA_W-1:0]          flash_dq_out,
	output logic                       flash_dq_oe_n,
	input  wire logic [DATA_W-1:0]     flash_dq_in,
	input  wire logic                  ready_busy_n
);
	import fws_pkg::*;

	typedef enum logic [8:0] {
		ST_IDLE   = 9'b000000001,
		ST_WRITE  = 9'b000000010,
		ST_SETTLE = 9'b000000100,
		ST_RD1    = 9'b000001000,
		ST_RD2    = 9'b000010000,
		ST_CHECK  = 9'b000100000,
		ST_DATA   = 9'b001000000,
		ST_RST    = 9'b010000000,
		ST_DONE   = 9'b100000000
	} fws_state_e;

	fws_state_e        state;
	fws_op_e           op;
	logic [ADDR_W-1:0] op_addr;
	logic [DATA_W-1:0] op_data;
	logic [2:0]        step;
	logic [2:0]        last_step;
	logic [7:0]        wait_cnt;
	logic [DATA_W-1:0] rd1;
	logic [DATA_W-1:0] rd2;
	logic              recheck;
	logic              op_ok;
	logic              rb_s1;
	logic              rb_s2;
	logic              toggling;
	logic              err_seen;
	logic              polled_op;

	fws_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

	// ********************************************************************
	// Command sequence table
	// ********************************************************************
	// Program and erase: unlock pattern, then the operation's own cycles; the last word carries the target, except chip erase at UNLOCK_ADDR1
	function automatic logic [ADDR_W+DATA_W-1:0] seq_word(fws_op_e o, logic [2:0] s,
	                                                      logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		logic [ADDR_W-1:0] u1;
		logic [ADDR_W-1:0] u2;
		u1 = ADDR_W'(UNLOCK_ADDR1);
		u2 = ADDR_W'(UNLOCK_ADDR2);
		seq_word = {a, DATA_W'(CMD_RESET)};
		case (o)
			FWS_OP_PROGRAM:
				case (s)
					3'h0:    seq_word = {u1, DATA_W'(CMD_UNLOCK1)};
					3'h1:    seq_word = {u2, DATA_W'(CMD_UNLOCK2)};
					3'h2:    seq_word = {u1, DATA_W'(CMD_PROGRAM)};
					default: seq_word = {a, d};
				endcase
			FWS_OP_SECTOR, FWS_OP_CHIP:
				case (s)
					3'h0, 3'h3: seq_word = {u1, DATA_W'(CMD_UNLOCK1)};
					3'h1, 3'h4: seq_word = {u2, DATA_W'(CMD_UNLOCK2)};
					3'h2:       seq_word = {u1, DATA_W'(CMD_ERASE_SETUP)};
					default:    seq_word = (o == FWS_OP_SECTOR) ? {a, DATA_W'(CMD_SECTOR_ERASE)}
					                                            : {u1, DATA_W'(CMD_CHIP_ERASE)};
				endcase
			FWS_OP_SUSPEND: seq_word = {a, DATA_W'(CMD_SUSPEND)};
			FWS_OP_RESUME:  seq_word = {a, DATA_W'(CMD_RESUME)};
			default:        seq_word = {a, DATA_W'(CMD_RESET)};
		endcase
	endfunction

	// ********************************************************************
	// Cycle request towards the pin engine
	// ********************************************************************
	// Reset write after failure reuses the engine; reads use the operation address, except chip erase reads at UNLOCK_ADDR1
	assign cyc.req   = (state == ST_WRITE) || (state == ST_RD1) || (state == ST_RD2) ||
	                   (state == ST_DATA) || (state == ST_RST);
	assign cyc.wr    = (state == ST_WRITE) || (state == ST_RST);
	assign {cyc.addr, cyc.wdata} = (state == ST_RST) ? {op_addr, DATA_W'(CMD_RESET)}
	                                                 : seq_word(op, step, op_addr, op_data);
	assign last_step = (op == FWS_OP_PROGRAM) ? PROGRAM_LAST :
	                   ((op == FWS_OP_SECTOR) || (op == FWS_OP_CHIP)) ? ERASE_LAST : 3'h0;
	assign polled_op = (op == FWS_OP_PROGRAM) || (op == FWS_OP_SECTOR) ||
	                   (op == FWS_OP_CHIP) || (op == FWS_OP_SUSPEND);
	assign toggling  = rd1[TOGGLE_ONE_POS] != rd2[TOGGLE_ONE_POS]; // Pair comparison [R15]
	assign err_seen  = rd2[TIMEOUT_ERR_POS];
	assign cmd_ready = state[0]; // Idle one-hot bit, straight from the state flop

	fws_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_eng (
		.core_clk      (core_clk),
		.nrst          (nrst),
		.clk_en        (clk_en),
		.cyc           (cyc.eng),
		.flash_ce_n    (flash_ce_n),
		.flash_oe_n    (flash_oe_n),
		.flash_we_n    (flash_we_n),
		.flash_addr    (flash_addr),
		.flash_dq_out  (flash_dq_out),
		.flash_dq_oe_n (flash_dq_oe_n),
		.flash_dq_in   (flash_dq_in)
	);

	// ********************************************************************
	// Ready/busy pin
	// ********************************************************************
	// Open-drain line from outside, two stages before use
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			rb_s1       <= 1'b1;
			rb_s2       <= 1'b1;
			device_busy <= 1'b0;
		end
		else if (clk_en)
		begin
			rb_s1       <= ready_busy_n;
			rb_s2       <= rb_s1;
			device_busy <= !rb_s2;
		end

	// ********************************************************************
	// Operation sequencer
	// ********************************************************************
	// Polling has no time limit: erases run for seconds, failure shows as error plus toggling
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			state    <= ST_IDLE;
			op       <= FWS_OP_READ;
			op_addr  <= '0;
			op_data  <= '0;
			step     <= 3'h0;
			wait_cnt <= 8'h00;
			rd1      <= '0;
			rd2      <= '0;
			recheck  <= 1'b0;
			op_ok    <= 1'b0;
		end
		else if (clk_en)
		begin
			case (state)
				ST_IDLE:
					if (cmd_valid)
					begin
						op      <= cmd_op;
						op_addr <= cmd_addr;
						op_data <= cmd_data;
						step    <= 3'h0;
						recheck <= 1'b0;
						op_ok   <= 1'b0;
						state   <= (cmd_op == FWS_OP_READ) ? ST_DATA : ST_WRITE;
					end
				ST_WRITE:
					if (cyc.done)
					begin
						if (step != last_step)
							step <= step + 3'h1;
						else if (polled_op)
						begin
							// Status only valid some time after the final strobe rise [R02]
							wait_cnt <= 8'(SETTLE_CYC - 1);
							state    <= ST_SETTLE;
						end
						else
						begin
							op_ok <= 1'b1;
							state <= ST_DONE;
						end
					end
				ST_SETTLE:
					if (wait_cnt == 8'h00)
						state <= ST_RD1;
					else
						wait_cnt <= wait_cnt - 8'h01;
				ST_RD1:
					if (cyc.done)
					begin
						rd1   <= cyc.rdata;
						state <= ST_RD2;
					end
				ST_RD2:
					if (cyc.done)
					begin
						rd2   <= cyc.rdata;
						state <= ST_CHECK;
					end
				ST_CHECK:
					if (!toggling)
						state <= ST_DATA; // Stopped toggle: success, next read is data [R15] [R16]
					else if (recheck)
						state <= ST_RST; // Still toggling after error: failure [R16]
					else
					begin
						// Error may show just as the toggle stops, so read a fresh pair [R12]
						recheck <= err_seen;
						state   <= ST_RD1;
					end
				ST_DATA:
					if (cyc.done)
					begin
						op_ok <= 1'b1;
						state <= ST_DONE;
					end
				ST_RST:
					if (cyc.done)
						state <= ST_DONE; // Back to array read after failure [R11]
				ST_DONE:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end

	// ********************************************************************
	// User answer and status capture
	// ********************************************************************
	// Answer pulses once per operation; status word holds the last compared read
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			resp_valid    <= 1'b0;
			resp_ok       <= 1'b0;
			resp_data     <= '0;
			status_word   <= STATUS_RESET;
			erase_started <= 1'b0;
		end
		else if (clk_en)
		begin
			resp_valid <= (state == ST_DONE);
			if (state == ST_DONE)
				resp_ok <= op_ok;
			if (state == ST_DATA && cyc.done)
				resp_data <= cyc.rdata;
			if (state == ST_CHECK)
				status_word <= rd2[STATUS_W-1:0];
			if (state == ST_IDLE && cmd_valid)
				erase_started <= 1'b0;
			else if (state == ST_CHECK && op == FWS_OP_SECTOR && rd2[ERASE_START_POS])
				erase_started <= 1'b1; // Sector erase has begun [R13]
		end

	// ********************************************************************
	// Assertions and covers
	// ********************************************************************
	a_reset_after_fail: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
		(clk_en && state == ST_RST && cyc.done) |=> (state == ST_DONE && !op_ok))
		else $error("failure did not end with reset write and failed answer");

	a_recheck_on_err: assert property (@(posedge core_clk) disable iff (!nrst) // [R12]
		(clk_en && state == ST_CHECK && toggling && err_seen && !recheck) |=> (state == ST_RD1 && recheck))
		else $error("error bit seen but toggle not rechecked");

	a_pair_compare: assert property (@(posedge core_clk) disable iff (!nrst) // [R15]
		(clk_en && state == ST_CHECK && !toggling) |=> (state == ST_DATA && status_word == $past(rd2[STATUS_W-1:0])))
		else $error("steady toggle pair did not lead to data read");

	a_toggle_fail: assert property (@(posedge core_clk) disable iff (!nrst) // [R16]
		(clk_en && state == ST_CHECK && toggling && recheck) |=> state == ST_RST)
		else $error("toggling after recheck not treated as failure");

	c_poll_ok: cover property (@(posedge core_clk) disable iff (!nrst)
		resp_valid && resp_ok && op == FWS_OP_PROGRAM);
	c_erase_ok: cover property (@(posedge core_clk) disable iff (!nrst)
		resp_valid && resp_ok && erase_started);
	c_fail: cover property (@(posedge core_clk) disable iff (!nrst)
		resp_valid && !resp_ok);

	// Widths the sequence table and counters rely on
	if (ADDR_W < UNLOCK_ADDR_W || DATA_W < STATUS_W || SETTLE_CYC > 255)
		$error("fws_host: ADDR_W >= 12, DATA_W >= 8 and settle count < 256 required");
endmodule

/* rtl/fws_pkg.sv */
// Constants, op codes and status bit layout shared by the flash status poll controller
//
// Contract
// R01 - Device ready_busy_n is open-drain, low while busy (the flash model drives it high when not busy)
// R02 - ready_busy_n valid after final write strobe rise
// R03 - ready_busy_n low programming/erasing, high when readable
// R04 - Busy reads return toggle_bit_one inverted each time
// R05 - After completion, toggling stops, array data returns
// R06 - Toggle valid after 4th (program) or 6th (erase) strobe
// R07 - Protected program: toggles about 2 us, then stops
// R08 - All-protected erase: toggles about 100 us, then reads
// R09 - timeout_error_bit set on pulse-limit overrun, else 0
// R10 - Programming 0 to 1 fails with timeout_error_bit
// R11 - Host writes reset command after failure
// R12 - Host rechecks toggle after seeing timeout_error_bit set
// R13 - erase_start_bit reads 1 after sector erase command
// R14 - toggle_bit_two toggles in selected erase sectors
// R15 - Host reads status twice, compares toggle bit
// R16 - Still toggling with error means failure, else success
// R17 - Program shows inverted_written_bit on data_poll_bit until done
// R18 - Erase shows data_poll_bit 0, then 1 when done
// R19 - Suspended sector: steady toggle one, toggling toggle two
// R20 - toggle_bit_one steady after completion or suspend acknowledged
// R21 - toggle_bit_two toggling with error flags sector failure
// R22 - During sector erase only suspend command honoured
// R23 - Toggle advances on each read strobe rising edge
package fws_pkg;

	// ********************************************************************
	// Timing, strobe, recover and settle counts derived from the 250 MHz core clock
	// ********************************************************************
	localparam int CLK_PS      = 4000;
	localparam int STROBE_NS   = 100;
	localparam int RECOVER_NS  = 20;
	localparam int SETTLE_NS   = 500;
	localparam int SYNC_CYC    = 2;
	localparam int STROBE_CYC  = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int SETTLE_CYC  = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;

	// ********************************************************************
	// Status word bit positions
	// ********************************************************************
	localparam int DATA_POLL_POS   = 7;
	localparam int TOGGLE_ONE_POS  = 6;
	localparam int TIMEOUT_ERR_POS = 5;
	localparam int ERASE_START_POS = 3;
	localparam int TOGGLE_TWO_POS  = 2;
	localparam int STATUS_W        = 8;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;

	// ********************************************************************
	// Command sequence values
	// ********************************************************************
	localparam int              UNLOCK_ADDR_W    = 12;
	localparam logic [11:0]     UNLOCK_ADDR1     = 12'h555;
	localparam logic [11:0]     UNLOCK_ADDR2     = 12'h2AA;
	localparam logic [7:0]      CMD_UNLOCK1      = 8'hAA;
	localparam logic [7:0]      CMD_UNLOCK2      = 8'h55;
	localparam logic [7:0]      CMD_PROGRAM      = 8'hA0;
	localparam logic [7:0]      CMD_ERASE_SETUP  = 8'h80;
	localparam logic [7:0]      CMD_CHIP_ERASE   = 8'h10;
	localparam logic [7:0]      CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0]      CMD_SUSPEND      = 8'hB0;
	localparam logic [7:0]      CMD_RESUME       = 8'h30;
	localparam logic [7:0]      CMD_RESET        = 8'hF0;
	localparam logic [2:0]      PROGRAM_LAST     = 3'h3;
	localparam logic [2:0]      ERASE_LAST       = 3'h5;

	// User operations
	typedef enum logic [2:0] {
		FWS_OP_READ    = 3'h0,
		FWS_OP_PROGRAM = 3'h1,
		FWS_OP_SECTOR  = 3'h2,
		FWS_OP_CHIP    = 3'h3,
		FWS_OP_SUSPEND = 3'h4,
		FWS_OP_RESUME  = 3'h5,
		FWS_OP_RESET   = 3'h6
	} fws_op_e;

endpackage

/* sim/fws_flash_model.sv */
// Behavioural flash device answering the poll controller on its pins
`timescale 1ns/1ps
module fws_flash_model
	import fws_pkg::*;
#(
	parameter int PROG_NS  = 3000,
	parameter int ERASE_NS = 20000,
	parameter int PROT_SEC = 3
)(
	// Host pins
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [21:0] addr,
	input  wire logic [15:0] dq_out,
	input  wire logic        dq_oe_n,
	// Device answers
	output logic      [15:0] dq_in,
	output logic             ready_busy_n
);
	typedef enum logic [2:0] {FWS_IDLE, FWS_PROG, FWS_ERASE, FWS_SUSP, FWS_SPROG} fws_mode_e;
	fws_mode_e   mode  = FWS_IDLE;
	logic [15:0] mem [int];
	logic [15:0] pdata = 16'h0000;
	logic [15:0] last  = 16'h0000;
	logic [6:0]  esec  = 7'h00;
	logic        t1    = 1'b0;
	logic        t2    = 1'b0;
	logic        err   = 1'b0;
	logic        chip  = 1'b0;
	int          step  = 0;
	int          gen   = 0;
	int          resets = 0;

	// ********************************************************************
	// Status word, array data and the shared line
	// ********************************************************************
	function automatic logic [15:0] rd_word(input logic [21:0] a);
		logic hit;
		hit = chip || (a[21:15] == esec);
		if (mode == FWS_IDLE || (mode == FWS_SUSP && !hit))
			return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
		if (mode == FWS_SUSP)
			return {8'h00, 1'b1, t1, 1'b0, 2'b00, t2, 2'b00};
		if (mode == FWS_ERASE)
			return {8'h00, 1'b0, t1, 1'b0, 1'b0, !chip, hit & t2, 2'b00};
		return {8'h00, ~pdata[7], t1, err, 2'b00, (mode == FWS_SPROG) & t2, 2'b00};
	endfunction

	// Released line shows the inverse of its last value, so stale data never passes
	always @(ce_n, oe_n, dq_oe_n, addr, dq_out, mode, t1, t2, err, last)
		dq_in = !dq_oe_n ? dq_out : ((!ce_n && !oe_n) ? rd_word(addr) : ~last);

	// Driven low while programming or erasing, driven high otherwise in place of the pull-up
	assign ready_busy_n = (mode == FWS_PROG || mode == FWS_ERASE || mode == FWS_SPROG) ? 1'b0 : 1'b1;

	// Toggles move once per finished read cycle
	always @(posedge oe_n or posedge ce_n)
	begin
		if (dq_oe_n && !(oe_n && ce_n))
		begin
			last <= dq_in;
			if (mode != FWS_IDLE && mode != FWS_SUSP)
				t1 <= !t1;
			if (mode != FWS_IDLE && mode != FWS_PROG && (chip || addr[21:15] == esec))
				t2 <= !t2;
		end
	end

	// ********************************************************************
	// Embedded operations
	// ********************************************************************
	task automatic finish_now(input fws_mode_e to, input int kind, input logic [21:0] a, input logic [15:0] v);
		logic [15:0] keep [int];
		if (kind == 2)
			err = 1'b1;
		else
			mode = to;
		if (kind == 1)
			mem[int'(a)] = v;
		if (kind == 3)
		begin
			foreach (mem[k])
				if (k[21:15] == PROT_SEC || (!chip && k[21:15] != esec))
					keep[k] = mem[k];
			mem = keep;
		end
	endtask

	// A newer operation cancels the pending end of an older one
	task automatic finish_after(input int ns, input fws_mode_e to, input int kind, input logic [21:0] a,
		input logic [15:0] v);
		int g;
		gen = gen + 1;
		g = gen;
		fork
			begin
				#(ns);
				if (g == gen)
					finish_now(to, kind, a, v);
			end
		join_none
	endtask

	task automatic command(input logic [21:0] a, input logic [15:0] d);
		logic [15:0] old;
		fws_mode_e   back;
		old = mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
		back = mode;
		if (d[7:0] == CMD_RESET && (mode == FWS_IDLE || err))
		begin
			mode = FWS_IDLE;
			err = 1'b0;
			step = 0;
			gen = gen + 1;
			resets = resets + 1;
		end
		else if (mode == FWS_ERASE)
		begin
			if (d[7:0] == CMD_SUSPEND && !chip)
				finish_after(1000, FWS_SUSP, 0, a, d);
		end
		else if (mode == FWS_SUSP && step == 0 && d[7:0] == CMD_RESUME)
		begin
			mode = FWS_ERASE;
			finish_after(ERASE_NS, FWS_IDLE, 3, a, d);
		end
		else if (mode == FWS_IDLE || mode == FWS_SUSP)
		begin
			case (step)
				0, 3: step = (a[11:0] == UNLOCK_ADDR1 && d[7:0] == CMD_UNLOCK1) ? step + 1 : 0;
				1, 4: step = (a[11:0] == UNLOCK_ADDR2 && d[7:0] == CMD_UNLOCK2) ? step + 1 : 0;
				2: step = (d[7:0] == CMD_PROGRAM) ? 6 : ((d[7:0] == CMD_ERASE_SETUP && mode == FWS_IDLE) ? 3 : 0);
				5:
				begin
					step = 0;
					chip = (d[7:0] == CMD_CHIP_ERASE);
					esec = a[21:15];
					if (chip || d[7:0] == CMD_SECTOR_ERASE)
					begin
						mode = FWS_ERASE;
						finish_after((!chip && esec == PROT_SEC) ? 100000 : ERASE_NS, FWS_IDLE, 3, a, d);
					end
				end
				default:
				begin
					step = 0;
					pdata = d;
					mode = (mode == FWS_SUSP) ? FWS_SPROG : FWS_PROG;
					if (a[21:15] == PROT_SEC)
						finish_after(2000, back, 0, a, d);
					else
						finish_after(PROG_NS, back, (|(d & ~old)) ? 2 : 1, a, d & old);
				end
			endcase
		end
	endtask

	// Commands latch at the write strobe rise
	always @(posedge we_n)
	begin
		if (!ce_n)
			command(addr, dq_out);
	end
endmodule

/* sim/tb_flash_write_status_reporting.sv */
// Self-checking bench for the flash status poll controller
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_flash_write_status_reporting;
	import fws_pkg::*;
	logic        core_clk  = 1'b0;
	logic        nrst      = 1'b0;
	logic        clk_en    = 1'b1;
	logic        cmd_valid = 1'b0;
	fws_op_e     cmd_op    = FWS_OP_READ;
	logic [21:0] cmd_addr  = 22'h000000;
	logic [15:0] cmd_data  = 16'h0000;
	logic        cmd_ready, resp_valid, resp_ok, erase_started, device_busy;
	logic [15:0] resp_data, dq_out, dq_in, r_data;
	logic [7:0]  status_word;
	logic        ce_n, oe_n, we_n, dq_oe_n, ready_busy_n, r_ok;
	logic        seen_busy = 1'b0;
	logic [21:0] faddr;
	int          miscompares = 0;
	int          checks_done = 0;

	fws_host #(.ADDR_W(22), .DATA_W(16)) dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.resp_valid(resp_valid), .resp_ok(resp_ok), .resp_data(resp_data), .status_word(status_word),
		.erase_started(erase_started), .device_busy(device_busy), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
		.flash_we_n(we_n), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
		.flash_dq_in(dq_in), .ready_busy_n(ready_busy_n));
	fws_flash_model flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .dq_in(dq_in), .ready_busy_n(ready_busy_n));

	// 250 MHz clock
	initial
	begin
		forever #2 core_clk = ~core_clk;
	end

	// Remembers whether busy was reported during the operation
	always @(posedge core_clk)
		if (device_busy === 1'b1)
			seen_busy <= 1'b1;

	task give_verdict;
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One user operation, held until taken, then waits for its answer
	task automatic xfer(input fws_op_e op, input logic [21:0] a, input logic [15:0] d);
		int n;
		@(negedge core_clk);
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		seen_busy = 1'b0;
		while (cmd_ready !== 1'b1)
			@(negedge core_clk);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		for (n = 0; n < 40000 && resp_valid !== 1'b1; n++)
			@(negedge core_clk);
		if (resp_valid !== 1'b1)
			miscompares++;
		r_ok = resp_ok;
		r_data = resp_data;
	endtask

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial
	begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		`CHECK({cmd_ready, ce_n, we_n, dq_oe_n, device_busy}, 5'h1E)
		xfer(FWS_OP_READ, 22'h000100, 16'h0000);
		`CHECK(r_data, 16'hFFFF)
		xfer(FWS_OP_PROGRAM, 22'h000100, 16'h1234);
		`CHECK({r_ok, seen_busy, status_word, r_data}, {2'b11, 8'h34, 16'h1234})
		xfer(FWS_OP_PROGRAM, 22'h000100, 16'h1235);
		`CHECK({r_ok, status_word[5]}, 2'b01)
		`CHECK(flash_u.resets, 1)
		xfer(FWS_OP_READ, 22'h000100, 16'h0000);
		`CHECK(r_data, 16'h1234)
		xfer(FWS_OP_PROGRAM, 22'h018010, 16'h0000);
		`CHECK({r_ok, r_data}, {1'b1, 16'hFFFF})
		xfer(FWS_OP_SECTOR, 22'h000000, 16'h0000);
		`CHECK({r_ok, erase_started, seen_busy}, 3'h7)
		xfer(FWS_OP_READ, 22'h000100, 16'h0000);
		`CHECK(r_data, 16'hFFFF)
		xfer(FWS_OP_PROGRAM, 22'h010004, 16'h00A5);
		xfer(FWS_OP_READ, 22'h010004, 16'h0000);
		`CHECK(r_data, 16'h00A5)
		xfer(FWS_OP_CHIP, 22'h000000, 16'h0000);
		`CHECK({r_ok, erase_started}, 2'b10)
		xfer(FWS_OP_READ, 22'h010004, 16'h0000);
		`CHECK(r_data, 16'hFFFF)
		xfer(FWS_OP_SECTOR, 22'h018000, 16'h0000);
		`CHECK({r_ok, device_busy}, 2'b10)
		xfer(FWS_OP_SUSPEND, 22'h000100, 16'h0000);
		`CHECK({r_ok, r_data}, {1'b1, 16'hFFFF})
		xfer(FWS_OP_RESUME, 22'h000100, 16'h0000);
		`CHECK({r_ok, device_busy}, 2'b10)
		xfer(FWS_OP_RESET, 22'h000100, 16'h0000);
		`CHECK({r_ok, flash_u.resets}, {1'b1, 32'd2})
		give_verdict();
	end

	// Watchdog, well beyond the expected run of about 160 us
	initial
	begin
		#300000;
		miscompares++;
		give_verdict();
	end
endmodule
